// >>> verification/ddmt_checker.sv
// Port-level assertions for the serial extension and counter block.
`timescale 1ns/1ps
`default_nettype none
module ddmt_checker (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic [3:0] addr_in,
  input wire logic rd_in,
  input wire logic wr_in,
  input wire logic [7:0] wdata_in,
  input wire logic [7:0] rdata_out,
  input wire logic [1:0] tx_write_out,
  input wire logic [7:0] tx_data_out,
  input wire logic [1:0] rx_bit_tick_in,
  input wire logic [1:0] rx_timeout_out,
  input wire logic [7:0] ct_src_tick_in,
  input wire logic output_pin_three_out,
  input wire logic ct_irq_out
);
  // **********************************************************
  // Shadows of write-only registers
  // **********************************************************
  logic [15:0] pre_reg;
  logic mask_reg;
  logic [1:0] opc_reg;
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      pre_reg <= 16'h0001;
      mask_reg <= 1'b0;
      opc_reg <= 2'h0;
    end else if (wr_in) begin
      if (addr_in == 4'h6) pre_reg[15:8] <= wdata_in;
      if (addr_in == 4'h7) pre_reg[7:0] <= wdata_in;
      if (addr_in == 4'h5) mask_reg <= wdata_in[3];
      if (addr_in == 4'hD) opc_reg <= wdata_in[3:2];
    end
  end
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  a_txw_cause: assert property (
    tx_write_out[0] |-> $past(wr_in && addr_in == 4'h3))
    else $error("transmit write without host buffer write");
  a_txd_data: assert property (
    |tx_write_out |-> tx_data_out == $past(wdata_in))
    else $error("transmit byte differs from host byte");
  a_wdog_pulse: assert property (
    rx_timeout_out[0] |-> $past(rx_bit_tick_in[0]) ##1 !rx_timeout_out[0])
    else $error("watchdog pulse not after a bit tick");
  a_stop_clear: assert property (
    rd_in && addr_in == ddmt_pkg::ADDR_CT_STOP && ct_src_tick_in == 8'h00
    |=> !ct_irq_out) else $error("stop read left counter interrupt");
  a_start_lo: assert property (
    rd_in && addr_in == ddmt_pkg::ADDR_CT_START ##1 rd_in && addr_in == 4'h7
    |=> rdata_out == pre_reg[7:0]) else $error("start did not load low");
  a_start_hi: assert property (
    rd_in && addr_in == ddmt_pkg::ADDR_CT_START ##1 rd_in && addr_in == 4'h6
    |=> rdata_out == pre_reg[15:8]) else $error("start did not load high");
  a_irq_masked: assert property (
    (!mask_reg) [*2] |-> !ct_irq_out) else $error("masked interrupt seen");
  a_pin3_idle: assert property (
    (opc_reg != ddmt_pkg::OUTPUT_PORT_CONFIG_OP3_CT) [*2] |-> output_pin_three_out)
    else $error("pin three not high while unselected");
  c_terminal: cover property ($rose(ct_irq_out));
  c_timeout: cover property (rx_timeout_out[0]);
  c_txw: cover property (tx_write_out[0]);
endmodule
bind ddmt_core ddmt_checker u_chk (
  .sys_clk_in(sys_clk_in), .rst_in(rst_in), .addr_in(addr_in),
  .rd_in(rd_in), .wr_in(wr_in), .wdata_in(wdata_in),
  .rdata_out(rdata_out), .tx_write_out(tx_write_out),
  .tx_data_out(tx_data_out), .rx_bit_tick_in(rx_bit_tick_in),
  .rx_timeout_out(rx_timeout_out), .ct_src_tick_in(ct_src_tick_in),
  .output_pin_three_out(output_pin_three_out), .ct_irq_out(ct_irq_out));
`default_nettype wire

// >>> verification/ddmt_far_model.sv
// Far side model: transmitter cores and a remote station on the line.
`timescale 1ns/1ps
`default_nettype none
module ddmt_far_model (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic [1:0] tx_write_in,
  input wire logic [7:0] tx_data_in,
  input wire logic [1:0] tx_tag_in,
  input wire logic send_in,
  input wire logic [7:0] send_data_in,
  output logic [1:0] tx_serial_out,
  output logic [1:0][1:0] tx_status_out,
  output logic [1:0] line_out
);
  // **********************************************************
  // Frame shifters
  // **********************************************************
  // One bit per clock keeps a whole frame inside a short capture.
  logic [1:0][10:0] tx_sh;
  logic [10:0] rm_sh;
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      tx_sh <= '1;
      rm_sh <= '1;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (tx_write_in[i]) begin
          tx_sh[i] <= {1'b1, tx_tag_in[i], tx_data_in, 1'b0};
        end else begin
          tx_sh[i] <= {1'b1, tx_sh[i][10:1]};
        end
      end
      rm_sh <= send_in ? {2'b11, send_data_in, 1'b0} : {1'b1, rm_sh[10:1]};
    end
  end
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      tx_serial_out[i] = tx_sh[i][0];
      tx_status_out[i] = {&tx_sh[i], 1'b1};
    end
  end
  // The remote line rests at mark between frames.
  assign line_out = {1'b1, rm_sh[0]};
endmodule
`default_nettype wire

// >>> verification/tb.sv
// Self-checking bench for the serial extension and counter block.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic sys_clk_in, rst_in, rd_in, wr_in, send, op3, ct_irq;
  logic [3:0] addr_in;
  logic [7:0] wdata_in, rdata_out, tx_data, ct_tick, send_data;
  logic [1:0] rx_pin, tx_pin, tx_core, rx_core, rx_valid, rx_tag, rx_fe;
  logic [1:0] rx_pe, rx_brk, bit_tick, tx_write, tx_tag, par_off, tmo;
  logic [1:0][7:0] rx_data;
  logic [1:0][1:0] tx_status;
  logic [11:0] p, c;
  int n_mismatch, n_compared, n_txw, n_tmo, cyc;
  localparam logic [11:0] F = {2'b11, 8'h5A, 2'b01};
  ddmt_core uut (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .addr_in(addr_in),
    .rd_in(rd_in), .wr_in(wr_in), .wdata_in(wdata_in),
    .rdata_out(rdata_out), .rx_pin_in(rx_pin), .tx_pin_out(tx_pin),
    .tx_core_serial_in(tx_core), .rx_core_serial_out(rx_core),
    .rx_char_valid_in(rx_valid), .rx_data_in(rx_data), .rx_tag_in(rx_tag),
    .rx_parity_err_in(rx_pe), .rx_frame_err_in(rx_fe),
    .rx_break_in(rx_brk), .rx_bit_tick_in(bit_tick),
    .tx_status_in(tx_status), .tx_write_out(tx_write),
    .tx_data_out(tx_data), .tx_tag_out(tx_tag), .parity_off_out(par_off),
    .rx_timeout_out(tmo), .ct_src_tick_in(ct_tick),
    .output_pin_three_out(op3), .ct_irq_out(ct_irq));
  ddmt_far_model far (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .tx_write_in(tx_write),
    .tx_data_in(tx_data), .tx_tag_in(tx_tag), .send_in(send),
    .send_data_in(send_data), .tx_serial_out(tx_core),
    .tx_status_out(tx_status), .line_out(rx_pin));
  // **********************************************************
  // Bus and stimulus tasks
  // **********************************************************
  task automatic results();
    $display("mismatches %0d comparisons %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge sys_clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= v;
    @(posedge sys_clk_in);
    wr_in <= 1'b0;
  endtask
  // Reads are sampled at the falling edge, once the registered data lands.
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input bit k);
    @(posedge sys_clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge sys_clk_in);
    rd_in <= 1'b0;
    @(negedge sys_clk_in);
    if (k) chk(rdata_out, e);
  endtask
  task automatic st(input logic [3:0] a, input logic [7:0] e);
    @(posedge sys_clk_in);
    rd_in <= 1'b1;
    addr_in <= ddmt_pkg::ADDR_CT_START;
    @(posedge sys_clk_in);
    addr_in <= a;
    @(posedge sys_clk_in);
    rd_in <= 1'b0;
    @(negedge sys_clk_in);
    chk(rdata_out, e);
  endtask
  // Ticks on the unselected sources must not move the count.
  task automatic tk(input int n);
    repeat (n) begin
      @(posedge sys_clk_in);
      ct_tick <= 8'h20;
      @(posedge sys_clk_in);
      ct_tick <= 8'hDF;
    end
    @(posedge sys_clk_in);
    ct_tick <= 8'h00;
  endtask
  task automatic rxc(input logic [7:0] v, input logic t, input logic f);
    @(posedge sys_clk_in);
    rx_valid <= 2'b01;
    rx_data[0] <= v;
    rx_tag <= {1'b0, t};
    rx_fe <= {1'b0, f};
    @(posedge sys_clk_in);
    rx_valid <= 2'b00;
  endtask
  task automatic bt(input int n);
    repeat (n) begin
      @(posedge sys_clk_in);
      bit_tick <= 2'b11;
      @(posedge sys_clk_in);
      bit_tick <= 2'b00;
    end
  endtask
  task automatic cap();
    for (int i = 0; i < 12; i++) begin
      @(negedge sys_clk_in);
      p[i] = tx_pin[0];
      c[i] = rx_core[0];
    end
  endtask
  initial begin
    sys_clk_in = 1'b0;
    forever #25 sys_clk_in = ~sys_clk_in;
  end
  always @(posedge sys_clk_in) begin
    cyc++;
    if (tx_write[0]) n_txw++;
    if (tmo[0]) n_tmo++;
    if (cyc == 20000) begin
      n_mismatch++;
      results();
    end
  end
  // **********************************************************
  // Test sequence
  // **********************************************************
  initial begin
    {rst_in, rd_in, wr_in, send, addr_in, wdata_in, ct_tick} = '0;
    {rx_valid, rx_tag, rx_fe, rx_pe, rx_brk, bit_tick, rx_data} = '0;
    send_data = 8'h00;
    rst_in = 1'b1;
    repeat (6) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    rd(4'h6, 8'h00, 1);
    wr(4'h4, 8'h50);
    wr(4'h5, 8'h08);
    wr(4'hD, 8'h04);
    wr(4'h6, 8'h00);
    wr(4'h7, 8'h03);
    st(4'h6, 8'h00);
    st(4'h7, 8'h03);
    chk(op3, 1'b0);
    tk(2);
    rd(4'h7, 8'h01, 1);
    chk(ct_irq, 1'b0);
    tk(1);
    chk(ct_irq, 1'b1);
    chk(op3, 1'b1);
    rd(4'h5, 8'h08, 1);
    tk(1);
    rd(4'h6, 8'hFF, 1);
    rd(4'h7, 8'hFF, 1);
    wr(4'h7, 8'h05);
    rd(4'h7, 8'hFF, 1);
    rd(4'hF, 8'h00, 0);
    chk(ct_irq, 1'b0);
    tk(2);
    rd(4'h7, 8'hFF, 1);
    wr(4'h5, 8'h00);
    st(4'h7, 8'h05);
    tk(5);
    rd(4'h5, 8'h08, 1);
    chk(ct_irq, 1'b0);
    rd(4'hF, 8'h00, 0);
    wr(4'h2, 8'hA1);
    wr(4'h7, 8'h03);
    rd(4'hE, 8'h00, 0);
    tk(2);
    rxc(8'h41, 1'b0, 1'b0);
    rd(4'h7, 8'h03, 1);
    tk(2);
    rd(4'h5, 8'h02, 1);
    tk(1);
    rd(4'h5, 8'h0A, 1);
    rd(4'h3, 8'h41, 1);
    wr(4'h2, 8'hC2);
    wr(4'h2, 8'h10);
    wr(4'h0, 8'h18);
    rxc(8'h11, 1'b0, 1'b0);
    rxc(8'h22, 1'b1, 1'b0);
    chk(par_off[0], 1'b1);
    rd(4'h1, 8'h2D, 1);
    rd(4'h3, 8'h22, 1);
    rd(4'h1, 8'h0C, 1);
    wr(4'h2, 8'h01);
    rxc(8'h33, 1'b0, 1'b1);
    rd(4'h1, 8'h4D, 1);
    rd(4'h3, 8'h33, 1);
    wr(4'h2, 8'hB0);
    wr(4'h0, 8'h80);
    rxc(8'h55, 1'b0, 1'b0);
    bt(63);
    chk(n_tmo[15:0], 16'h0000);
    bt(1);
    repeat (2) @(posedge sys_clk_in);
    chk(n_tmo[15:0], 16'h0001);
    rd(4'h3, 8'h55, 1);
    for (int m = 0; m < 4; m++) begin
      wr(4'h2, 8'h10);
      wr(4'h0, {5'h00, m[1], 2'h0});
      wr(4'h0, {m[1:0], 6'h00});
      @(posedge sys_clk_in);
      send <= 1'b1;
      send_data <= 8'h5A;
      @(posedge sys_clk_in);
      send <= 1'b0;
      cap();
      chk(p, m[0] ? F : 12'hFFF);
      chk(c, m[1] ? 12'hFFF : F);
      chk(tx_tag[0], m[1]);
      wr(4'h3, 8'hA5);
      cap();
      chk(p, (m == 0) ? {m[1], 8'hA5, 3'h3} : 12'hFFF);
      chk(c, (m == 2) ? {m[1], 8'hA5, 3'h3} : 12'hFFF);
      if (m == 3) begin
        rxc(8'h44, 1'b0, 1'b0);
        rd(4'h3, 8'h00, 1);
      end
    end
    chk(n_txw[15:0], 16'h0002);
    wr(4'h2, 8'h10);
    wr(4'h0, 8'h00);
    wr(4'h0, 8'h00);
    rd(4'h3, 8'h44, 1);
    // Channel B runs on its own, with the counter flag still standing.
    wr(4'hA, 8'h01);
    @(posedge sys_clk_in);
    rx_valid <= 2'b10;
    rx_data[1] <= 8'h66;
    @(posedge sys_clk_in);
    rx_valid <= 2'b00;
    rd(4'h5, 8'h28, 1);
    rd(4'hB, 8'h66, 1);
    chk({tx_pin[1], rx_core[1]}, 16'h0003);
    results();
  end
endmodule
`default_nettype wire

// >>> verilog/ddmt_core.sv
// Loop modes, multidrop receive, receive watchdog and counter/timer.
`timescale 1ns/1ps
`default_nettype none

module ddmt_core (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic [3:0] addr_in,
  input wire logic rd_in,
  input wire logic wr_in,
  input wire logic [7:0] wdata_in,
  output logic [7:0] rdata_out,
  input wire logic [1:0] rx_pin_in,
  output logic [1:0] tx_pin_out,
  input wire logic [1:0] tx_core_serial_in,
  output logic [1:0] rx_core_serial_out,
  input wire logic [1:0] rx_char_valid_in,
  input wire logic [1:0][7:0] rx_data_in,
  input wire logic [1:0] rx_tag_in,
  input wire logic [1:0] rx_parity_err_in,
  input wire logic [1:0] rx_frame_err_in,
  input wire logic [1:0] rx_break_in,
  input wire logic [1:0] rx_bit_tick_in,
  input wire logic [1:0][1:0] tx_status_in,
  output logic [1:0] tx_write_out,
  output logic [7:0] tx_data_out,
  output logic [1:0] tx_tag_out,
  output logic [1:0] parity_off_out,
  output logic [1:0] rx_timeout_out,
  input wire logic [7:0] ct_src_tick_in,
  output logic output_pin_three_out,
  output logic ct_irq_out
);

  typedef struct packed {
    logic [1:0][1:0] ptr;
    logic [1:0][7:0] mode0;
    logic [1:0][7:0] mode1;
    logic [1:0][7:0] mode2;
    logic [1:0] rx_en;
    logic [1:0] mdrop;
    logic [1:0][7:0][10:0] fifo;
    logic [1:0][2:0] wp;
    logic [1:0][2:0] rp;
    logic [1:0][3:0] cnt;
    logic [1:0] ovr;
    logic [1:0][5:0] wd_cnt;
    logic [1:0] wd_run;
    logic [1:0] wd_irq;
    logic [1:0] txd;
    logic [1:0] rxd;
    logic [1:0] txwr;
    logic [7:0] txdata;
    logic [2:0] ct_src;
    logic [7:0] interrupt_mask;
    logic [1:0] op3_sel;
    logic [15:0] preload;
    logic [15:0] ct;
    logic ct_run;
    logic ct_rdy;
    logic ct_level;
    logic to_en;
    logic to_ch;
    logic op3;
    logic irq;
    logic [7:0] rdata;
  } ddmt_state_s;

  ddmt_state_s s_reg;
  ddmt_state_s s_next;

  // ************************************************************
  // Next-state logic
  // ************************************************************
  always_comb begin
    logic [1:0] push;
    logic [1:0] pop;
    logic [1:0] keep;
    logic [1:0] sel;
    logic [1:0] lp;
    logic [10:0] head;
    logic tick;
    logic start;
    logic stop;
    logic reload;
    push = '0;
    pop = '0;
    keep = '0;
    sel = '0;
    lp = '0;
    head = '0;
    tick = ct_src_tick_in[s_reg.ct_src];
    start = rd_in && (addr_in == ddmt_pkg::ADDR_CT_START);
    stop = rd_in && (addr_in == ddmt_pkg::ADDR_CT_STOP);
    reload = 1'b0;
    s_next = s_reg;
    s_next.txwr = '0;
    s_next.wd_irq = '0;
    if (rd_in) begin
      s_next.rdata = ddmt_pkg::READ_IDLE;
    end
    for (int c = 0; c < 2; c++) begin
      sel[c] = (addr_in[3] == 1'(c)) && !addr_in[2];
      lp = s_reg.mode2[c][7:6];
      head = s_reg.fifo[c][s_reg.rp[c]];
      // Serial routing; the pin and core paths pick up one flop of delay.
      unique case (lp)
        ddmt_pkg::LOOP_NORMAL: begin
          s_next.txd[c] = tx_core_serial_in[c];
          s_next.rxd[c] = rx_pin_in[c];
        end
        ddmt_pkg::LOOP_ECHO: begin
          s_next.txd[c] = rx_pin_in[c];
          s_next.rxd[c] = rx_pin_in[c];
        end
        ddmt_pkg::LOOP_LOCAL: begin
          s_next.txd[c] = 1'b1;
          s_next.rxd[c] = tx_core_serial_in[c];
        end
        ddmt_pkg::LOOP_REMOTE: begin
          // Idle mark keeps the local receiver from assembling anything.
          s_next.txd[c] = rx_pin_in[c];
          s_next.rxd[c] = 1'b1;
        end
      endcase
      s_next.mdrop[c] = (s_next.mode1[c][4:3] ==
                         ddmt_pkg::PARITY_MULTIDROP);
      // The line is watched even with the receiver off in multidrop.
      if (s_reg.mdrop[c]) begin
        keep[c] = s_reg.rx_en[c] || rx_tag_in[c];
      end else begin
        keep[c] = s_reg.rx_en[c];
      end
      if (rx_char_valid_in[c] && keep[c]) begin
        if (s_reg.cnt[c] == ddmt_pkg::FIFO_FULL) begin
          s_next.ovr[c] = 1'b1;
        end else begin
          push[c] = 1'b1;
        end
      end
      if (push[c]) begin
        s_next.fifo[c][s_reg.wp[c]] = {rx_break_in[c], rx_frame_err_in[c],
          s_reg.mdrop[c] ? rx_tag_in[c] : rx_parity_err_in[c],
          rx_data_in[c]};
        s_next.wp[c] = s_reg.wp[c] + 3'h1;
      end
      pop[c] = rd_in && sel[c] && (addr_in[1:0] == ddmt_pkg::OFS_BUF) &&
               (s_reg.cnt[c] != 4'h0) && (lp != ddmt_pkg::LOOP_REMOTE);
      if (pop[c]) begin
        s_next.rp[c] = s_reg.rp[c] + 3'h1;
      end
      s_next.cnt[c] = s_reg.cnt[c] + 4'(push[c]) - 4'(pop[c]);
      // Watchdog counts receive bit ticks, so its span follows the rate.
      if (!s_reg.mode0[c][ddmt_pkg::MR0_WDOG_BIT]) begin
        s_next.wd_run[c] = 1'b0;
      end else if (push[c]) begin
        s_next.wd_run[c] = 1'b1;
        s_next.wd_cnt[c] = 6'h00;
      end else if (s_reg.wd_run[c] && rx_bit_tick_in[c]) begin
        if (s_reg.wd_cnt[c] == ddmt_pkg::WD_LAST) begin
          s_next.wd_run[c] = 1'b0;
          s_next.wd_irq[c] = 1'b1;
        end else begin
          s_next.wd_cnt[c] = s_reg.wd_cnt[c] + 6'h01;
        end
      end
      if (wr_in && sel[c]) begin
        unique case (addr_in[1:0])
          ddmt_pkg::OFS_MODE: begin
            if (s_reg.ptr[c] == ddmt_pkg::PTR_MR0) begin
              s_next.mode0[c] = wdata_in;
              s_next.ptr[c] = ddmt_pkg::PTR_MR1;
            end else if (s_reg.ptr[c] == ddmt_pkg::PTR_MR1) begin
              s_next.mode1[c] = wdata_in;
              s_next.ptr[c] = ddmt_pkg::PTR_MR2;
            end else begin
              s_next.mode2[c] = wdata_in;
            end
          end
          ddmt_pkg::OFS_STATUS: begin
          end
          ddmt_pkg::OFS_CMD: begin
            if (wdata_in[1:0] == ddmt_pkg::CMD_RX_ENA) begin
              s_next.rx_en[c] = 1'b1;
            end else if (wdata_in[1:0] == ddmt_pkg::CMD_RX_DIS) begin
              s_next.rx_en[c] = 1'b0;
            end
            if (wdata_in[7:4] == ddmt_pkg::CMD_PTR_MR1) begin
              s_next.ptr[c] = ddmt_pkg::PTR_MR1;
            end else if (wdata_in[7:4] == ddmt_pkg::CMD_PTR_MR0) begin
              s_next.ptr[c] = ddmt_pkg::PTR_MR0;
            end else if (wdata_in[7:4] == ddmt_pkg::CMD_TO_ON) begin
              s_next.to_en = 1'b1;
              s_next.to_ch = 1'(c);
            end else if (wdata_in[7:4] == ddmt_pkg::CMD_TO_OFF) begin
              s_next.to_en = 1'b0;
            end
          end
          ddmt_pkg::OFS_BUF: begin
            if (lp == ddmt_pkg::LOOP_NORMAL || lp == ddmt_pkg::LOOP_LOCAL)
            begin
              s_next.txwr[c] = 1'b1;
              s_next.txdata = wdata_in;
            end
          end
        endcase
      end
      if (rd_in && sel[c]) begin
        unique case (addr_in[1:0])
          ddmt_pkg::OFS_MODE: begin
            if (s_reg.ptr[c] == ddmt_pkg::PTR_MR0) begin
              s_next.rdata = s_reg.mode0[c];
              s_next.ptr[c] = ddmt_pkg::PTR_MR1;
            end else if (s_reg.ptr[c] == ddmt_pkg::PTR_MR1) begin
              s_next.rdata = s_reg.mode1[c];
              s_next.ptr[c] = ddmt_pkg::PTR_MR2;
            end else begin
              s_next.rdata = s_reg.mode2[c];
            end
          end
          ddmt_pkg::OFS_STATUS: begin
            s_next.rdata = {head[ddmt_pkg::ENT_BRK], head[ddmt_pkg::ENT_FE],
              head[ddmt_pkg::ENT_TAG], s_reg.ovr[c], tx_status_in[c],
              s_reg.cnt[c] == ddmt_pkg::FIFO_FULL,
              s_reg.cnt[c] != 4'h0};
          end
          ddmt_pkg::OFS_CMD: begin
          end
          ddmt_pkg::OFS_BUF: begin
            if (pop[c]) begin
              s_next.rdata = head[7:0];
            end
          end
        endcase
      end
    end
    if (wr_in) begin
      unique case (addr_in)
        ddmt_pkg::ADDR_AUX: s_next.ct_src = wdata_in[6:4];
        ddmt_pkg::ADDR_INT: s_next.interrupt_mask = wdata_in;
        ddmt_pkg::ADDR_CT_UPPER: s_next.preload[15:8] = wdata_in;
        ddmt_pkg::ADDR_CT_LOWER: s_next.preload[7:0] = wdata_in;
        ddmt_pkg::ADDR_OUT_CFG: s_next.op3_sel = wdata_in[3:2];
        default: begin
        end
      endcase
    end
    if (rd_in) begin
      unique case (addr_in)
        ddmt_pkg::ADDR_INT: begin
          s_next.rdata[ddmt_pkg::ISR_RX_A_BIT] = s_reg.cnt[0] != 4'h0;
          s_next.rdata[ddmt_pkg::ISR_CT_BIT] = s_reg.ct_rdy;
          s_next.rdata[ddmt_pkg::ISR_RX_B_BIT] = s_reg.cnt[1] != 4'h0;
        end
        ddmt_pkg::ADDR_CT_UPPER: s_next.rdata = s_reg.ct[15:8];
        ddmt_pkg::ADDR_CT_LOWER: s_next.rdata = s_reg.ct[7:0];
        default: begin
        end
      endcase
    end
    // ************************************************************
    // Counter/timer, counter mode only
    // ************************************************************
    reload = s_reg.to_en && push[s_reg.to_ch];
    if (stop) begin
      s_next.ct_run = 1'b0;
      s_next.ct_rdy = 1'b0;
    end
    if (start || reload) begin
      // Preload is sampled only here, so later writes wait for this.
      s_next.ct = s_reg.preload;
      s_next.ct_run = 1'b1;
      s_next.ct_level = 1'b0;
    end else if (s_reg.ct_run && tick) begin
      s_next.ct = s_reg.ct - 16'h0001;
      if (s_reg.ct == ddmt_pkg::CT_ONE) begin
        // Terminal count beats a stop read landing in the same cycle.
        s_next.ct_rdy = 1'b1;
        s_next.ct_level = 1'b1;
      end
    end
    s_next.op3 = (s_next.op3_sel == ddmt_pkg::OUTPUT_PORT_CONFIG_OP3_CT) ?
                 s_next.ct_level : 1'b1;
    s_next.irq = s_next.ct_rdy && s_next.interrupt_mask[ddmt_pkg::ISR_CT_BIT];
  end

  // ************************************************************
  // State register
  // ************************************************************
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      // Cleared state is counter mode with the counter stopped.
      s_reg <= '0;
      s_reg.ptr <= {ddmt_pkg::PTR_MR1, ddmt_pkg::PTR_MR1};
      s_reg.txd <= 2'h3;
      s_reg.rxd <= 2'h3;
      s_reg.op3 <= 1'b1;
      s_reg.preload <= ddmt_pkg::PRELOAD_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign rdata_out = s_reg.rdata;
  assign tx_pin_out = s_reg.txd;
  assign rx_core_serial_out = s_reg.rxd;
  assign tx_write_out = s_reg.txwr;
  assign tx_data_out = s_reg.txdata;
  assign tx_tag_out = {s_reg.mode1[1][ddmt_pkg::MR1_TAG_BIT],
                       s_reg.mode1[0][ddmt_pkg::MR1_TAG_BIT]};
  assign parity_off_out = s_reg.mdrop;
  assign rx_timeout_out = s_reg.wd_irq;
  assign output_pin_three_out = s_reg.op3;
  assign ct_irq_out = s_reg.irq;

endmodule

`default_nettype wire

// >>> verilog/ddmt_pkg.sv
// Constants shared by the serial channel extensions and counter/timer.
package ddmt_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [1:0] OFS_MODE = 2'h0;
  localparam logic [1:0] OFS_STATUS = 2'h1;
  localparam logic [1:0] OFS_CMD = 2'h2;
  localparam logic [1:0] OFS_BUF = 2'h3;
  localparam logic [3:0] ADDR_AUX = 4'h4;
  localparam logic [3:0] ADDR_INT = 4'h5;
  localparam logic [3:0] ADDR_CT_UPPER = 4'h6;
  localparam logic [3:0] ADDR_CT_LOWER = 4'h7;
  localparam logic [3:0] ADDR_OUT_CFG = 4'hD;
  localparam logic [3:0] ADDR_CT_START = 4'hE;
  localparam logic [3:0] ADDR_CT_STOP = 4'hF;

  // ************************************************************
  // Field positions and codes
  // ************************************************************
  localparam int MR0_WDOG_BIT = 7;
  localparam int MR1_TAG_BIT = 2;
  localparam int ISR_RX_A_BIT = 1;
  localparam int ISR_CT_BIT = 3;
  localparam int ISR_RX_B_BIT = 5;
  localparam int ENT_BRK = 10;
  localparam int ENT_FE = 9;
  localparam int ENT_TAG = 8;
  localparam logic [1:0] PARITY_MULTIDROP = 2'h3;
  localparam logic [1:0] OUTPUT_PORT_CONFIG_OP3_CT = 2'h1;
  localparam logic [3:0] CMD_PTR_MR1 = 4'h1;
  localparam logic [3:0] CMD_TO_ON = 4'hA;
  localparam logic [3:0] CMD_PTR_MR0 = 4'hB;
  localparam logic [3:0] CMD_TO_OFF = 4'hC;
  localparam logic [1:0] CMD_RX_ENA = 2'h1;
  localparam logic [1:0] CMD_RX_DIS = 2'h2;
  localparam logic [1:0] PTR_MR0 = 2'h0;
  localparam logic [1:0] PTR_MR1 = 2'h1;
  localparam logic [1:0] PTR_MR2 = 2'h2;

  typedef enum logic [1:0] {
    LOOP_NORMAL = 2'h0,
    LOOP_ECHO = 2'h1,
    LOOP_LOCAL = 2'h2,
    LOOP_REMOTE = 2'h3
  } ddmt_loop_e;

  // ************************************************************
  // Sizes, counts and reset values
  // ************************************************************
  localparam int FIFO_DEPTH = 8;
  localparam logic [3:0] FIFO_FULL = 4'(FIFO_DEPTH);
  localparam int WD_BIT_TIMES = 64;
  localparam logic [5:0] WD_LAST = 6'(WD_BIT_TIMES - 1);
  localparam logic [15:0] CT_ONE = 16'h0001;
  localparam logic [15:0] PRELOAD_RESET = 16'h0001;
  localparam logic [7:0] READ_IDLE = 8'h00;

endpackage
